// >>> rx_ctrl_pkg.sv
/*
 * Constants and carrier types for the per-channel receive path control
 * register. Assumes a byte-wide host parallel port on SYS_CLK.
 */
package rx_ctrl_pkg;

    localparam logic [7:0] RX_CTRL_OFFSET   = 8'h05;
    localparam logic [7:0] RX_CTRL_RESET    = 8'h00;
    localparam logic [7:0] RX_CTRL_WMASK    = 8'h3F;
    localparam int         DIG_DIS_BIT      = 5;
    localparam int         ANA_DIS_BIT      = 4;
    localparam int         EDGE_SEL_BIT     = 3;
    localparam int         MUTE_BIT         = 2;
    localparam int         MONITOR_BIT      = 1;
    localparam int         EQ_EN_BIT        = 0;

    typedef enum logic [1:0]
    {
        MODE_DS3  = 2'b00,
        MODE_STS1 = 2'b01,
        MODE_E3   = 2'b10
    } line_mode_e;

    typedef struct packed
    {
        logic pos;
        logic neg;
    } rail_s;

endpackage

// >>> receive_path_control.sv
/*
 * Receive path control register of one line channel and the receive-side
 * controls it drives: detector enables, mute, monitor mode, equalizer and
 * recovered data launch edge.
 * Assumes host strobes, detector flags and recovered data are synchronous
 * to SYS_CLK; the recovered clock is an ordinary sampled input.
 */
// Behaviour
// - Bit 5 at 1 stops the digital signal-absent detector; 0 runs it.
// - Bit 4 at 1 stops the analog signal-absent detector; 0 runs it.
// - Detector disables act only in DS3 or STS-1 mode, never in E3.
// - Bit 3 at 0 launches recovered rail data on recovered clock rising edge.
// - Bit 2 at 1 holds both rails low while signal-absent defect declared.
// - Bit 1 monitor mode suppresses every signal-absent indication.
// - Bit 0 at 1 enables the receive equalizer; 0 bypasses it.
`timescale 1ns/1ns
module receive_path_control
(
    // Clock and reset
    input  wire logic                    SYS_CLK,
    input  wire logic                    NRST,
    // Host parallel port
    input  wire logic [7:0]              ADDR,
    input  wire logic                    WR_EN,
    input  wire logic                    RD_EN,
    input  wire logic [7:0]              WDATA,
    output logic      [7:0]              RDATA,
    // Channel mode
    input  wire rx_ctrl_pkg::line_mode_e LINE_MODE,
    // Detector raw flags
    input  wire logic                    DIG_ABSENT_RAW,
    input  wire logic                    ANA_ABSENT_RAW,
    // Recovered data path
    input  wire logic                    RECOVERED_CLOCK_OUTPUT,
    input  wire rx_ctrl_pkg::rail_s      RAIL_IN,
    output rx_ctrl_pkg::rail_s           RECOVERED_RAIL,
    // Receive section controls
    output logic                         DIG_DETECTOR_EN,
    output logic                         ANA_DETECTOR_EN,
    output logic                         EQUALIZER_EN,
    output logic                         MONITOR_MODE,
    output logic                         SIGNAL_ABSENT_DEFECT
);

    logic [5:0]         ctrl_q;
    logic               clk_s1_q;
    logic               clk_s2_q;
    logic               clk_prev_q;
    logic               los_en_mode;
    logic               dig_run;
    logic               ana_run;
    logic               defect_d;
    logic               launch;
    rx_ctrl_pkg::rail_s rail_d;

    // Assertions share one clock and sleep through reset
    default clocking chk_cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!NRST);

    // Register write; reserved bits never stored
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            ctrl_q <= rx_ctrl_pkg::RX_CTRL_RESET[5:0];
        else if (WR_EN && ADDR == rx_ctrl_pkg::RX_CTRL_OFFSET)
            ctrl_q <= WDATA[5:0] & rx_ctrl_pkg::RX_CTRL_WMASK[5:0];
    end

    // Readback; unmapped addresses read zero
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            RDATA <= 8'h00;
        else if (RD_EN && ADDR == rx_ctrl_pkg::RX_CTRL_OFFSET)
            RDATA <= {2'b00, ctrl_q};
        else
            RDATA <= 8'h00;
    end

    // Disables are ignored in E3, where detectors always run
    always_comb
    begin
        los_en_mode = (LINE_MODE != rx_ctrl_pkg::MODE_E3);
        dig_run     = !(los_en_mode && ctrl_q[rx_ctrl_pkg::DIG_DIS_BIT]);
        ana_run     = !(los_en_mode && ctrl_q[rx_ctrl_pkg::ANA_DIS_BIT]);
        defect_d    = !ctrl_q[rx_ctrl_pkg::MONITOR_BIT]
                      && ((dig_run && DIG_ABSENT_RAW)
                          || (ana_run && ANA_ABSENT_RAW));
    end

    // Control outputs
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            DIG_DETECTOR_EN      <= 1'b1;
            ANA_DETECTOR_EN      <= 1'b1;
            EQUALIZER_EN         <= 1'b0;
            MONITOR_MODE         <= 1'b0;
            SIGNAL_ABSENT_DEFECT <= 1'b0;
        end
        else
        begin
            DIG_DETECTOR_EN      <= dig_run;
            ANA_DETECTOR_EN      <= ana_run;
            EQUALIZER_EN         <= ctrl_q[rx_ctrl_pkg::EQ_EN_BIT];
            MONITOR_MODE         <= ctrl_q[rx_ctrl_pkg::MONITOR_BIT];
            SIGNAL_ABSENT_DEFECT <= defect_d;
        end
    end

    // Recovered clock comes from another domain: two-stage sync first
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            clk_s1_q   <= 1'b0;
            clk_s2_q   <= 1'b0;
            clk_prev_q <= 1'b0;
        end
        else
        begin
            clk_s1_q   <= RECOVERED_CLOCK_OUTPUT;
            clk_s2_q   <= clk_s1_q;
            clk_prev_q <= clk_s2_q;
        end
    end

    // Edge choice; sampled clock limits this model to slow rates
    always_comb
    begin
        if (ctrl_q[rx_ctrl_pkg::EDGE_SEL_BIT])
            launch = clk_prev_q && !clk_s2_q;
        else
            launch = !clk_prev_q && clk_s2_q;
        rail_d = RECOVERED_RAIL;
        if (ctrl_q[rx_ctrl_pkg::MUTE_BIT] && defect_d)
            rail_d = '0;
        else if (launch)
            rail_d = RAIL_IN;
    end

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            RECOVERED_RAIL <= '0;
        else
            RECOVERED_RAIL <= rail_d;
    end

    reserved_zero_a: assert property (RDATA[7:6] == 2'b00)
        else $error("Reserved bits read nonzero");

    readback_a: assert property (
        (WR_EN && ADDR == rx_ctrl_pkg::RX_CTRL_OFFSET) ##1
        (RD_EN && !WR_EN && ADDR == rx_ctrl_pkg::RX_CTRL_OFFSET)
        |=> RDATA[5:0] == $past(WDATA[5:0], 2))
        else $error("Readback differs from write");

    dig_disable_a: assert property (
        (ctrl_q[5] && LINE_MODE != rx_ctrl_pkg::MODE_E3)
        |=> !DIG_DETECTOR_EN)
        else $error("Digital detector not disabled");

    dig_enable_a: assert property (
        !ctrl_q[5] |=> DIG_DETECTOR_EN)
        else $error("Digital detector not running");

    dig_seen_a: assert property (
        (!ctrl_q[1] && DIG_ABSENT_RAW && !ctrl_q[5]) |=> SIGNAL_ABSENT_DEFECT)
        else $error("Digital absence not declared");

    ana_disable_a: assert property (
        (ctrl_q[4] && LINE_MODE != rx_ctrl_pkg::MODE_E3)
        |=> !ANA_DETECTOR_EN)
        else $error("Analog detector not disabled");

    ana_enable_a: assert property (
        !ctrl_q[4] |=> ANA_DETECTOR_EN)
        else $error("Analog detector not running");

    ana_seen_a: assert property (
        (!ctrl_q[1] && ANA_ABSENT_RAW && !ctrl_q[4]) |=> SIGNAL_ABSENT_DEFECT)
        else $error("Analog absence not declared");

    e3_ignores_a: assert property (
        (LINE_MODE == rx_ctrl_pkg::MODE_E3)
        |=> (DIG_DETECTOR_EN && ANA_DETECTOR_EN))
        else $error("Detector disabled in E3 mode");

    rise_launch_a: assert property (
        (!ctrl_q[3] && !clk_prev_q && clk_s2_q && !defect_d)
        |=> RECOVERED_RAIL == $past(RAIL_IN))
        else $error("Rails not launched on rising edge");

    rise_hold_a: assert property (
        (!ctrl_q[3] && clk_prev_q && !clk_s2_q && !defect_d)
        |=> RECOVERED_RAIL == $past(RECOVERED_RAIL))
        else $error("Rails launched on falling edge");

    fall_launch_a: assert property (
        (ctrl_q[3] && clk_prev_q && !clk_s2_q && !defect_d)
        |=> RECOVERED_RAIL == $past(RAIL_IN))
        else $error("Rails not launched on falling edge");

    fall_hold_a: assert property (
        (ctrl_q[3] && !clk_prev_q && clk_s2_q && !defect_d)
        |=> RECOVERED_RAIL == $past(RECOVERED_RAIL))
        else $error("Rails launched on rising edge");

    mute_low_a: assert property (
        (ctrl_q[2] && defect_d) |=> (RECOVERED_RAIL == '0)
        && SIGNAL_ABSENT_DEFECT)
        else $error("Rails not muted during defect");

    mute_off_a: assert property (
        (!ctrl_q[2] && !launch) |=> RECOVERED_RAIL == $past(RECOVERED_RAIL))
        else $error("Rails changed without launch");

    monitor_quiet_a: assert property (
        ctrl_q[1] |=> !SIGNAL_ABSENT_DEFECT)
        else $error("Defect raised in monitor mode");

    monitor_copy_a: assert property (
        ##1 MONITOR_MODE == $past(ctrl_q[1]))
        else $error("Monitor mode output mismatch");

    equalizer_a: assert property (
        ##1 EQUALIZER_EN == $past(ctrl_q[0]))
        else $error("Equalizer enable mismatch");

endmodule

// >>> host_model.sv
/*
 * Host processor model: byte writes and reads on the parallel port.
 * Assumes SYS_CLK from the bench; drives at the falling edge.
 */
`timescale 1ns/1ns
module host_model
(
    // Clock
    input  wire logic       clk,
    // Host parallel port
    output logic      [7:0] addr,
    output logic            wr_en,
    output logic            rd_en,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata
);
    initial
    begin
        addr  = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr  = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        wdata = ~d; // Stale data never lingers
    endtask
    // Read data stands one cycle only, so it is taken right away
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr  = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        d     = rdata;
    endtask
    // Write then read with no idle cycle between them
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        @(negedge clk);
        addr  = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        wdata = ~d;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        q     = rdata;
    endtask
endmodule

// >>> receive_path_control_bench.sv
/*
 * Bench for the receive path control register.
 * Assumes the host model drives the port; inputs change at falling edge.
 */
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, a, e); end end
module receive_path_control_bench;
    logic                    sys_clk = 1'b0;
    logic                    nrst = 1'b0;
    logic [7:0]              addr, wdata, rdata, rv;
    logic                    wr_en, rd_en, dig_en, ana_en, eq_en, mon, defect;
    logic                    dig_raw = 1'b0, ana_raw = 1'b0, rclk = 1'b0;
    rx_ctrl_pkg::line_mode_e mode = rx_ctrl_pkg::MODE_DS3;
    rx_ctrl_pkg::rail_s      rail_in = 2'b00, rail_out;
    int                      n_errors = 0, cmp_count = 0;
    host_model host (.clk(sys_clk), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wdata(wdata), .rdata(rdata));
    receive_path_control dut (.SYS_CLK(sys_clk), .NRST(nrst), .ADDR(addr),
        .WR_EN(wr_en), .RD_EN(rd_en), .WDATA(wdata), .RDATA(rdata),
        .LINE_MODE(mode), .DIG_ABSENT_RAW(dig_raw), .ANA_ABSENT_RAW(ana_raw),
        .RECOVERED_CLOCK_OUTPUT(rclk), .RAIL_IN(rail_in),
        .RECOVERED_RAIL(rail_out), .DIG_DETECTOR_EN(dig_en),
        .ANA_DETECTOR_EN(ana_en), .EQUALIZER_EN(eq_en), .MONITOR_MODE(mon),
        .SIGNAL_ABSENT_DEFECT(defect));
    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic settle();
        repeat (3) @(negedge sys_clk);
    endtask
    // Recovered clock level change, rails held across the launch
    task automatic launch(input logic [1:0] v, input logic lvl);
        @(negedge sys_clk);
        rail_in = v;
        rclk    = lvl;
        repeat (5) @(negedge sys_clk);
    endtask
    task automatic t_reset();
        host.rd(rx_ctrl_pkg::RX_CTRL_OFFSET, rv);
        `CHK(rv, rx_ctrl_pkg::RX_CTRL_RESET)
        `CHK({dig_en, ana_en, eq_en, mon}, 4'b1100)
        $display("reset test done");
    endtask
    task automatic t_fields();
        host.wr(8'h05, 8'hFF);
        host.wr(8'h06, 8'h00);
        host.rd(8'h05, rv);
        `CHK(rv, 8'h3F)
        host.rd(8'h06, rv);
        `CHK(rv, 8'h00)
        dig_raw = 1'b1;
        ana_raw = 1'b1;
        settle();
        `CHK({dig_en, ana_en, eq_en, mon, defect}, 5'b00110)
        mode = rx_ctrl_pkg::MODE_E3;
        settle();
        `CHK({dig_en, ana_en}, 2'b11)
        `CHK(defect, 1'b0)
        mode = rx_ctrl_pkg::MODE_STS1;
        host.wr(8'h05, 8'h05);
        settle();
        `CHK({dig_en, ana_en, eq_en, mon}, 4'b1110)
        `CHK({defect, rail_out}, 3'b100)
        dig_raw = 1'b0;
        ana_raw = 1'b0;
        $display("field test done");
    endtask
    task automatic t_edge();
        host.wr(8'h05, 8'h01);
        launch(2'b10, 1'b1);
        `CHK(rail_out, 2'b10)
        launch(2'b01, 1'b0);
        `CHK(rail_out, 2'b10)
        host.wr(8'h05, 8'h09);
        launch(2'b11, 1'b1);
        `CHK(rail_out, 2'b10)
        launch(2'b01, 1'b0);
        `CHK(rail_out, 2'b01)
        $display("edge test done");
    endtask
    task automatic t_split();
        host.wr(8'h05, 8'h21);
        dig_raw = 1'b1;
        settle();
        `CHK({dig_en, ana_en, defect}, 3'b010)
        ana_raw = 1'b1;
        settle();
        `CHK(defect, 1'b1)
        host.wr(8'h05, 8'h11);
        dig_raw = 1'b0;
        settle();
        `CHK({dig_en, ana_en, defect}, 3'b100)
        dig_raw = 1'b1;
        settle();
        `CHK(defect, 1'b1)
        dig_raw = 1'b0;
        ana_raw = 1'b0;
        host.wr_rd(8'h05, 8'hD2, rv);
        `CHK(rv, 8'h12)
        `CHK(mon, 1'b1)
        $display("split test done");
    endtask
    // Rails must be nonzero first, or muting proves nothing
    task automatic t_mute();
        ana_raw = 1'b1;
        settle();
        `CHK({defect, rail_out}, 3'b101)
        host.wr(8'h05, 8'h0D);
        settle();
        `CHK({defect, rail_out}, 3'b100)
        launch(2'b11, 1'b1);
        launch(2'b11, 1'b0);
        `CHK(rail_out, 2'b00)
        ana_raw = 1'b0;
        settle();
        `CHK({defect, rail_out}, 3'b000)
        launch(2'b10, 1'b1);
        launch(2'b10, 1'b0);
        `CHK(rail_out, 2'b10)
        $display("mute test done");
    endtask
    task automatic finish_test();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge sys_clk);
        nrst = 1'b1;
        t_reset();
        t_fields();
        t_split();
        t_edge();
        t_mute();
        finish_test();
    end
    initial
    begin
        #200000;
        n_errors++;
        finish_test();
    end
endmodule
